// ### core/osr_pkg.sv
package osr_pkg;

	// ---------------------------------------------------------------
	// Register addresses (7-bit serial address space)
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_REVISION   = 7'h01;
	localparam logic [6:0] ADDR_DELTA_X    = 7'h03;
	localparam logic [6:0] ADDR_DELTA_Y    = 7'h04;
	localparam logic [6:0] ADDR_SQUAL      = 7'h05;
	localparam logic [6:0] ADDR_EXPO_HIGH  = 7'h06;
	localparam logic [6:0] ADDR_EXPO_LOW   = 7'h07;
	localparam logic [6:0] ADDR_BRIGHTEST  = 7'h08;
	localparam logic [6:0] ADDR_TOTAL      = 7'h09;
	localparam logic [6:0] ADDR_DARKEST    = 7'h0a;
	localparam logic [6:0] ADDR_SAMPLE     = 7'h0b;
	localparam logic [6:0] ADDR_CONFIG     = 7'h0d;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h3a;
	localparam logic [6:0] ADDR_INV_VER    = 7'h3f;
	localparam logic [6:0] ADDR_BULK       = 7'h63;

	// ---------------------------------------------------------------
	// Fields, keys and reset values
	// ---------------------------------------------------------------
	localparam int         CFG_CPI_BIT     = 0;
	localparam int         CFG_POWER_BIT   = 1;
	localparam int         SAMPLE_VALID_BIT = 7;
	localparam logic [7:0] RESET_KEY       = 8'h5a;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;
	localparam logic [15:0] EXPO_RESET     = 16'h0100;
	localparam logic [15:0] EXPO_MIN       = 16'h0001;
	localparam logic [15:0] EXPO_MAX       = 16'hff00;
	localparam logic [15:0] EXPO_STEP      = 16'h0010;

	// ---------------------------------------------------------------
	// Frame statistics
	// ---------------------------------------------------------------
	localparam logic [7:0]  PIXEL_COUNT    = 8'he1;
	localparam logic [7:0]  LAST_PIXEL     = 8'he0;
	localparam logic [6:0]  PIXEL_FULL     = 7'h7f;
	localparam int          TOTAL_HI       = 14;
	localparam int          TOTAL_LO       = 7;
	localparam logic [7:0]  TOTAL_MAX      = 8'hdf;
	localparam logic [6:0]  BRIGHT_HIGH    = 7'h70;
	localparam logic [6:0]  BRIGHT_LOW     = 7'h40;
	localparam logic [14:0] SUM_HIGH       = 15'h5dc0;
	localparam logic [14:0] SUM_LOW        = 15'h1c20;

	// ---------------------------------------------------------------
	// Bulk read sequence
	// ---------------------------------------------------------------
	localparam logic [2:0] BULK_LAST       = 3'h6;

	// Kind of request passed from the link to the register side
	typedef enum logic [1:0] {
		REQ_ADDR  = 2'b00,
		REQ_NEXT  = 2'b01,
		REQ_WRITE = 2'b10
	} osr_req_t;

endpackage

// ### core/osr_readout_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Exposure read high byte then low byte
// - Exposure self-adjusts to keep pixels in range
// - Brightest pixel 0..127, every frame while powered up
// - Fifteen-bit pixel sum, report bits 14:7
// - Brightness total reads 0..223
// - Darkest pixel 0..127, every frame while powered up
// - Sampler grabs at most one pixel per frame
// - Valid sampler read sets bit7, advances, re-arms
// - Sampler write rearms at pixel 0 next image
// - Config bit1 power down, bit0 resolution
// - Writing key 0x5a starts chip reset
// - Inverted version reads complement of revision
// - Bulk register read enters burst mode
// - Burst returns seven motion and statistic bytes
// - Past last byte, brightness total repeats
// - Chip select high ends burst mode
// - Displacements two's complement, cleared by reading
module osr_readout_regs
	import osr_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = 8'h03  // Arbitrary value
) (
	// System
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Serial link
	input  wire logic       sclk,
	input  wire logic       chip_select_n,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe,
	// Imaging core
	input  wire logic       frame_start,
	input  wire logic       frame_end,
	input  wire logic       pixel_valid,
	input  wire logic [6:0] pixel_value,
	// Motion core
	input  wire logic       motion_valid,
	input  wire logic [7:0] motion_dx,
	input  wire logic [7:0] motion_dy,
	input  wire logic [7:0] surface_quality,
	// Controls to the core
	output logic [15:0]     exposure,
	output logic            power_down_select,
	output logic            counts_per_inch_select
);

	// ---------------------------------------------------------------
	// Link side (serial clock domain)
	// ---------------------------------------------------------------
	logic [3:0]  link_bits;
	logic [7:0]  link_shift_in;
	logic        link_write;
	logic [6:0]  link_addr;
	logic [7:0]  link_wdata;
	osr_req_t    link_kind;
	logic        link_req;
	logic [7:0]  link_shift_out;
	logic [7:0]  rd_data;

	// Bit counter and write-flag capture; chip select high clears the frame
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			link_bits     <= 4'h0;
			link_shift_in <= 8'h00;
			link_write    <= 1'b0;
		end else begin
			link_shift_in <= {link_shift_in[6:0], sdio_in};
			link_bits     <= (link_bits == 4'hf) ? 4'h8 : link_bits + 4'h1;
			if (link_bits == 4'h7)
				link_write <= link_shift_in[6];
		end
	end

	// Request toggle survives chip select so no event is lost or doubled
	always_ff @(posedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			link_req   <= 1'b0;
			link_kind  <= REQ_ADDR;
			link_addr  <= 7'h00;
			link_wdata <= 8'h00;
		end else if (!chip_select_n) begin
			if (link_bits == 4'h7) begin
				link_addr <= {link_shift_in[5:0], sdio_in};
				if (!link_shift_in[6]) begin
					link_kind <= REQ_ADDR;
					link_req  <= ~link_req;
				end
			end else if (link_bits == 4'hf) begin
				link_kind <= link_write ? REQ_WRITE : REQ_NEXT;
				link_req  <= ~link_req;
				if (link_write)
					link_wdata <= {link_shift_in[6:0], sdio_in};
			end
		end
	end

	// Read data is quasi-static: the master waits after each address
	// or byte before clocking, so rd_data has settled when it is loaded
	always_ff @(negedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			link_shift_out <= 8'h00;
			sdio_out       <= 1'b0;
			sdio_oe        <= 1'b0;
		end else if (link_bits == 4'h8 && !link_write) begin
			link_shift_out <= {rd_data[6:0], 1'b0};
			sdio_out       <= rd_data[7];
			sdio_oe        <= 1'b1;
		end else begin
			link_shift_out <= {link_shift_out[6:0], 1'b0};
			sdio_out       <= link_shift_out[7];
		end
	end

	// ---------------------------------------------------------------
	// Crossing into the system clock
	// ---------------------------------------------------------------
	logic [2:0] req_sync;
	logic [1:0] cs_sync;
	logic       soft_rst;

	// Two flops each; the third req stage only forms the edge
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_sync <= 3'b000;
			cs_sync  <= 2'b11;
		end else begin
			req_sync <= {req_sync[1:0], link_req};
			cs_sync  <= {cs_sync[0], chip_select_n};
		end
	end

	wire core_rst  = sys_rst | soft_rst;
	wire req_edge  = req_sync[2] ^ req_sync[1];
	wire cs_high   = cs_sync[1];
	wire addr_read = req_edge && link_kind == REQ_ADDR;
	wire wr_event  = req_edge && link_kind == REQ_WRITE;

	// ---------------------------------------------------------------
	// Burst sequencing
	// ---------------------------------------------------------------
	logic       burst_active;
	logic [2:0] burst_index;

	// Address of each burst slot in return order
	function automatic logic [6:0] bulk_slot(input logic [2:0] idx);
		case (idx)
			3'h0:    bulk_slot = ADDR_DELTA_X;
			3'h1:    bulk_slot = ADDR_DELTA_Y;
			3'h2:    bulk_slot = ADDR_SQUAL;
			3'h3:    bulk_slot = ADDR_EXPO_HIGH;
			3'h4:    bulk_slot = ADDR_EXPO_LOW;
			3'h5:    bulk_slot = ADDR_BRIGHTEST;
			default: bulk_slot = ADDR_TOTAL;
		endcase
	endfunction

	wire       start_burst = addr_read && link_addr == ADDR_BULK;
	wire       step_burst  = req_edge && link_kind == REQ_NEXT && burst_active && !cs_high;
	wire [2:0] next_index  = (burst_index == BULK_LAST) ? BULK_LAST : burst_index + 3'h1;
	wire [6:0] sel_addr    = start_burst ? ADDR_DELTA_X :
	                         step_burst  ? bulk_slot(next_index) : link_addr;
	wire       reg_read    = addr_read || step_burst;
	wire       reg_write   = wr_event;

	// Burst enters on a bulk read and leaves when chip select rises
	always_ff @(posedge clock) begin
		if (core_rst || cs_high) begin
			burst_active <= 1'b0;
			burst_index  <= 3'h0;
		end else if (addr_read) begin
			burst_active <= start_burst;
			burst_index  <= 3'h0;
		end else if (step_burst) begin
			burst_index  <= next_index;
		end
	end

	// ---------------------------------------------------------------
	// Motion, configuration and reset key
	// ---------------------------------------------------------------
	logic [7:0] delta_x;
	logic [7:0] delta_y;
	logic [7:0] squal;

	// Saturating signed add keeps a fast swipe from wrapping direction
	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {a[7], a} + {b[7], b};
		sat_add = (s[8] != s[7]) ? {s[8], {7{~s[8]}}} : s[7:0];
	endfunction

	wire       core_on  = !power_down_select;
	wire       mot_in   = motion_valid && core_on;
	wire [7:0] next_dx  = sat_add((reg_read && sel_addr == ADDR_DELTA_X) ? 8'h00 : delta_x,
	                              mot_in ? motion_dx : 8'h00);
	wire [7:0] next_dy  = sat_add((reg_read && sel_addr == ADDR_DELTA_Y) ? 8'h00 : delta_y,
	                              mot_in ? motion_dy : 8'h00);

	// Read clears the count, but motion in the same cycle is kept
	always_ff @(posedge clock) begin
		if (core_rst) begin
			delta_x <= REG_RESET_VALUE;
			delta_y <= REG_RESET_VALUE;
			squal   <= REG_RESET_VALUE;
		end else begin
			delta_x <= next_dx;
			delta_y <= next_dy;
			if (mot_in)
				squal <= surface_quality;
		end
	end

	// Only the two defined config bits are stored
	always_ff @(posedge clock) begin
		if (core_rst) begin
			power_down_select      <= 1'b0;
			counts_per_inch_select <= 1'b0;
		end else if (reg_write && link_addr == ADDR_CONFIG) begin
			power_down_select      <= link_wdata[CFG_POWER_BIT];
			counts_per_inch_select <= link_wdata[CFG_CPI_BIT];
		end
	end

	// Key write pulses the internal reset for one cycle
	always_ff @(posedge clock) begin
		if (sys_rst)
			soft_rst <= 1'b0;
		else
			soft_rst <= reg_write && link_addr == ADDR_SOFT_RESET && link_wdata == RESET_KEY;
	end

	// ---------------------------------------------------------------
	// Frame statistics and exposure control
	// ---------------------------------------------------------------
	logic [6:0]  run_max;
	logic [6:0]  run_min;
	logic [14:0] run_sum;
	logic [6:0]  brightest;
	logic [6:0]  darkest;
	logic [7:0]  brightness_total;
	logic [7:0]  expo_low_latch;

	wire pix_in      = pixel_valid && core_on;
	wire fend_in     = frame_end && core_on;
	wire too_bright  = run_max > BRIGHT_HIGH || run_sum > SUM_HIGH;
	wire too_dark    = run_max < BRIGHT_LOW && run_sum < SUM_LOW;

	// Running extremes and sum, latched at the end of each frame while not powered down
	always_ff @(posedge clock) begin
		if (core_rst) begin
			run_max          <= 7'h00;
			run_min          <= PIXEL_FULL;
			run_sum          <= 15'h0000;
			brightest        <= 7'h00;
			darkest          <= 7'h00;
			brightness_total <= REG_RESET_VALUE;
		end else if (frame_start && core_on) begin
			run_max <= 7'h00;
			run_min <= PIXEL_FULL;
			run_sum <= 15'h0000;
		end else if (pix_in) begin
			if (pixel_value > run_max)
				run_max <= pixel_value;
			if (pixel_value < run_min)
				run_min <= pixel_value;
			run_sum <= run_sum + {8'h00, pixel_value};
		end else if (fend_in) begin
			brightest        <= run_max;
			darkest          <= run_min;
			brightness_total <= run_sum[TOTAL_HI:TOTAL_LO];
		end
	end

	// One step per frame; slow on purpose so the loop never oscillates
	always_ff @(posedge clock) begin
		if (core_rst)
			exposure <= EXPO_RESET;
		else if (fend_in && too_bright)
			exposure <= (exposure > EXPO_MIN + EXPO_STEP) ? exposure - EXPO_STEP : EXPO_MIN;
		else if (fend_in && too_dark)
			exposure <= (exposure < EXPO_MAX - EXPO_STEP) ? exposure + EXPO_STEP : EXPO_MAX;
	end

	// Low byte is frozen when the high byte is read so the pair agrees
	always_ff @(posedge clock) begin
		if (core_rst)
			expo_low_latch <= REG_RESET_VALUE;
		else if (reg_read && sel_addr == ADDR_EXPO_HIGH)
			expo_low_latch <= exposure[7:0];
	end

	// ---------------------------------------------------------------
	// Frame sampler
	// ---------------------------------------------------------------
	logic [7:0] pix_pos;
	logic [7:0] grab_index;
	logic [6:0] grab_pixel;
	logic       grab_valid;
	logic       grab_done;

	wire grab_hit   = pix_in && !grab_valid && !grab_done && pix_pos == grab_index;
	wire grab_rd    = reg_read && sel_addr == ADDR_SAMPLE && grab_valid;
	wire grab_wr    = reg_write && link_addr == ADDR_SAMPLE;

	// Pixel position within the current frame
	always_ff @(posedge clock) begin
		if (core_rst || (frame_start && core_on))
			pix_pos <= 8'h00;
		else if (pix_in && pix_pos != PIXEL_COUNT)
			pix_pos <= pix_pos + 8'h01;
	end

	// grab_done blocks a second capture until the next frame starts
	always_ff @(posedge clock) begin
		if (core_rst) begin
			grab_index <= 8'h00;
			grab_pixel <= 7'h00;
			grab_valid <= 1'b0;
			grab_done  <= 1'b0;
		end else if (grab_wr) begin
			grab_index <= 8'h00;
			grab_valid <= 1'b0;
			grab_done  <= 1'b1;
		end else begin
			if (frame_start && core_on)
				grab_done <= 1'b0;
			if (grab_hit) begin
				grab_pixel <= pixel_value;
				grab_valid <= 1'b1;
				grab_done  <= 1'b1;
			end else if (grab_rd) begin
				grab_valid <= 1'b0;
				grab_index <= (grab_index == LAST_PIXEL) ? 8'h00 : grab_index + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Read data selection
	// ---------------------------------------------------------------
	logic [7:0] read_value;

	// Unmapped addresses read as zero
	always_comb begin
		case (sel_addr)
			ADDR_REVISION:  read_value = REVISION_CODE;
			ADDR_DELTA_X:   read_value = delta_x;
			ADDR_DELTA_Y:   read_value = delta_y;
			ADDR_SQUAL:     read_value = squal;
			ADDR_EXPO_HIGH: read_value = exposure[15:8];
			ADDR_EXPO_LOW:  read_value = expo_low_latch;
			ADDR_BRIGHTEST: read_value = {1'b0, brightest};
			ADDR_TOTAL:     read_value = brightness_total;
			ADDR_DARKEST:   read_value = {1'b0, darkest};
			ADDR_SAMPLE:    read_value = {grab_valid, grab_pixel};
			ADDR_CONFIG:    read_value = {6'h00, power_down_select, counts_per_inch_select};
			ADDR_INV_VER:   read_value = ~REVISION_CODE;
			default:        read_value = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (core_rst)
			rd_data <= 8'h00;
		else if (reg_read)
			rd_data <= read_value;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_expo_pair;
		@(posedge clock) disable iff (core_rst) reg_read && sel_addr == ADDR_EXPO_HIGH
			|=> expo_low_latch == $past(exposure[7:0]) && rd_data == $past(exposure[15:8]);
	endproperty
	a_expo_pair: assert property (p_expo_pair) else $error("exposure pair mismatch");

	property p_expo_down;
		@(posedge clock) disable iff (core_rst) fend_in && too_bright && exposure > EXPO_MIN
			|=> exposure < $past(exposure);
	endproperty
	a_expo_down: assert property (p_expo_down) else $error("exposure not reduced");

	property p_bright_range;
		@(posedge clock) disable iff (core_rst) fend_in && !pix_in && !frame_start
			|=> brightest == $past(run_max) && darkest == $past(run_min);
	endproperty
	a_bright_range: assert property (p_bright_range) else $error("extremes not latched");

	property p_total_bits;
		@(posedge clock) disable iff (core_rst) fend_in && !pix_in && !frame_start
			|=> brightness_total == $past(run_sum[14:7]) && brightness_total <= TOTAL_MAX;
	endproperty
	a_total_bits: assert property (p_total_bits) else $error("total wrong");

	property p_grab_read;
		@(posedge clock) disable iff (core_rst) grab_rd && !grab_wr && grab_index != LAST_PIXEL
			|=> rd_data[SAMPLE_VALID_BIT] && !grab_valid && grab_index == $past(grab_index) + 8'h01;
	endproperty
	a_grab_read: assert property (p_grab_read) else $error("sampler read failed");

	property p_grab_write;
		@(posedge clock) disable iff (core_rst) grab_wr |=> grab_index == 8'h00 && !grab_valid ##1 !grab_valid;
	endproperty
	a_grab_write: assert property (p_grab_write) else $error("sampler not rearmed");

	property p_config;
		@(posedge clock) disable iff (core_rst) reg_write && link_addr == ADDR_CONFIG
			|=> power_down_select == $past(link_wdata[1]) && counts_per_inch_select == $past(link_wdata[0]);
	endproperty
	a_config: assert property (p_config) else $error("config not stored");

	property p_reset_key;
		@(posedge clock) disable iff (sys_rst) reg_write && link_addr == ADDR_SOFT_RESET && link_wdata == RESET_KEY
			|=> soft_rst ##1 exposure == EXPO_RESET;
	endproperty
	a_reset_key: assert property (p_reset_key) else $error("soft reset missing");

	property p_burst_first;
		@(posedge clock) disable iff (core_rst) start_burst && !mot_in |=> rd_data == $past(delta_x) && delta_x == 8'h00;
	endproperty
	a_burst_first: assert property (p_burst_first) else $error("burst first byte wrong");

	property p_burst_hold;
		@(posedge clock) disable iff (core_rst) step_burst && burst_index == BULK_LAST
			|=> rd_data == $past(brightness_total) && burst_index == BULK_LAST;
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst did not hold");

	property p_burst_exit;
		@(posedge clock) disable iff (core_rst) cs_high |=> !burst_active;
	endproperty
	a_burst_exit: assert property (p_burst_exit) else $error("burst not ended");

	c_burst_hold: cover property (@(posedge clock) step_burst && burst_index == BULK_LAST);
	c_grab_read:  cover property (@(posedge clock) grab_rd);
	c_soft_reset: cover property (@(posedge clock) soft_rst);
	c_expo_adj:   cover property (@(posedge clock) fend_in && too_dark);

endmodule  // osr_readout_regs

// ### dv/osr_mcu_model.sv
`timescale 1ns/1ps
// ----
// Serial master in place of the host controller
// ----
module osr_mcu_model
	import osr_pkg::*;
(
	// Serial link
	output logic      sclk,
	output logic      chip_select_n,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe
);
	localparam int HALF = 32; // 64 ns link period
	localparam int GAP  = 70; // Device needs 60 ns before the first data bit
	logic [7:0] bulk [0:8];

	// Link clock stands high between frames
	initial begin
		sclk = 1'b1;
		chip_select_n = 1'b0;
		sdio_in = 1'b0;
		#2;
		chip_select_n = 1'b1; // A real rising edge clears the link counters
	end

	// Device samples on the rising edge, so data changes on the falling one
	task automatic put_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			sdio_in = b[i];
			#HALF;
			sclk = 1'b1;
			#HALF;
		end
	endtask

	// Our data line is released here, so it wanders instead of holding
	task automatic get_byte(output logic [7:0] b);
		#GAP;
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			sdio_in = ~sdio_in;
			#HALF;
			sclk = 1'b1;
			b[i] = sdio_out;
			#HALF;
		end
	endtask

	task automatic open_frame();
		chip_select_n = 1'b0;
		#HALF;
	endtask

	// Raising select is the only clean way out of a burst
	task automatic close_frame();
		#HALF;
		chip_select_n = 1'b1;
		sdio_in = ~sdio_in;
		#(4*HALF);
	endtask

	task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
		open_frame();
		put_byte({1'b0, a});
		get_byte(d);
		close_frame();
	endtask

	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		open_frame();
		put_byte({1'b1, a});
		put_byte(d);
		close_frame();
	endtask

	task automatic bulk_read(input int n);
		open_frame();
		put_byte({1'b0, ADDR_BULK});
		for (int k = 0; k < n; k++) begin
			get_byte(bulk[k]);
		end
		close_frame();
	endtask
endmodule // osr_mcu_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import osr_pkg::*;
;
	localparam logic [7:0] REV_CODE = 8'h5c; // Arbitrary value
	localparam int         LIMIT    = 40000;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b0;
	logic        sclk, chip_select_n, sdio_in, sdio_out, sdio_oe;
	logic        frame_start, frame_end, pixel_valid, motion_valid;
	logic [6:0]  pixel_value;
	logic [7:0]  motion_dx, motion_dy, surface_quality, got;
	logic [15:0] exposure;
	logic        power_down_select, counts_per_inch_select;
	int          miscompares = 0, check_count = 0, cycles = 0, seed;
	int          r_max, r_min, r_tot, r_expo, r_dx, r_dy, r_sq, r_sleep;
	int          s_arm, s_idx, s_val, s_held;
	int          want [9];

	always #5 clock = ~clock;

	osr_readout_regs #(.REVISION_CODE(REV_CODE)) u_dut (.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
		.chip_select_n(chip_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.frame_start(frame_start), .frame_end(frame_end), .pixel_valid(pixel_valid),
		.pixel_value(pixel_value), .motion_valid(motion_valid), .motion_dx(motion_dx),
		.motion_dy(motion_dy), .surface_quality(surface_quality), .exposure(exposure),
		.power_down_select(power_down_select), .counts_per_inch_select(counts_per_inch_select));
	osr_mcu_model u_mcu (.sclk(sclk), .chip_select_n(chip_select_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe));

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hung link would otherwise stall forever
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task automatic check_word(input logic [15:0] g, input logic [15:0] e, input string m);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e, input string m);
		u_mcu.read_reg(a, got);
		check_byte(got, e, m);
	endtask

	// ----
	// Reference model
	// ----
	function automatic int sat(input int v);
		return v > 127 ? 127 : (v < -128 ? -128 : v);
	endfunction

	task automatic ref_reset();
		r_max = 0;
		r_min = 0;
		r_tot = 0;
		r_dx = 0;
		r_dy = 0;
		r_sq = 0;
		r_sleep = 0;
		r_expo = int'(EXPO_RESET);
		s_val = 0;
	endtask

	// One whole frame of 225 pixels, stats and exposure step folded in
	task automatic run_frame(input int mode);
		int p, mx, mn, sum, n;
		mx = 0;
		mn = 127;
		sum = 0;
		@(negedge clock);
		frame_start = 1'b1;
		@(negedge clock);
		frame_start = 1'b0;
		for (int i = 0; i < 225; i++) begin
			p = (mode == 1) ? 127 : $urandom_range(mode == 2 ? 31 : 127);
			mx = (p > mx) ? p : mx;
			mn = (p < mn) ? p : mn;
			sum += p;
			if (s_arm && i == s_idx && !r_sleep) begin
				s_held = p;
				s_val = 1;
				s_arm = 0;
			end
			pixel_valid = 1'b1;
			pixel_value = 7'(p);
			@(negedge clock);
		end
		pixel_valid = 1'b0;
		frame_end = 1'b1;
		@(negedge clock);
		frame_end = 1'b0;
		if (!r_sleep) begin
			r_max = mx;
			r_min = mn;
			r_tot = sum >> 7;
			if (mx > int'(BRIGHT_HIGH) || sum > int'(SUM_HIGH)) begin
				n = r_expo - int'(EXPO_STEP);
				r_expo = n < int'(EXPO_MIN) ? int'(EXPO_MIN) : n;
			end else if (mx < int'(BRIGHT_LOW) && sum < int'(SUM_LOW)) begin
				n = r_expo + int'(EXPO_STEP);
				r_expo = n > int'(EXPO_MAX) ? int'(EXPO_MAX) : n;
			end
		end
	endtask

	task automatic grab(input string m);
		logic [7:0] e;
		e = {s_val[0], 7'(s_held)};
		if (s_val) begin
			s_val = 0;
			s_arm = 1;
			s_idx = (s_idx == 224) ? 0 : s_idx + 1;
		end
		rd(ADDR_SAMPLE, e, m);
	endtask

	task automatic move(input int dx, input int dy, input int sq);
		@(negedge clock);
		motion_valid = 1'b1;
		motion_dx = 8'(dx);
		motion_dy = 8'(dy);
		surface_quality = 8'(sq);
		@(negedge clock);
		motion_valid = 1'b0;
		r_dx = sat(r_dx + dx);
		r_dy = sat(r_dy + dy);
		r_sq = sq;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		seed = $urandom(32'h3a6c);
		#1;
		sys_rst = 1'b1; // Raised after time zero so the link flops see a real edge
		{frame_start, frame_end, pixel_valid, motion_valid} = 4'h0;
		pixel_value = 7'h00;
		{motion_dx, motion_dy, surface_quality} = 24'h000000;
		ref_reset();
		repeat (3) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		rd(ADDR_EXPO_HIGH, 8'(r_expo >> 8), "expo high");
		rd(ADDR_EXPO_LOW, 8'(r_expo), "expo low");
		rd(ADDR_REVISION, REV_CODE, "revision");
		rd(ADDR_INV_VER, ~REV_CODE, "inverted version");
		rd(7'h0c, 8'h00, "unmapped");
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			u_mcu.write_reg(ADDR_CONFIG, {6'($urandom), 2'(k)});
			r_sleep = k >> 1;
			rd(ADDR_CONFIG, 8'(k), "config");
			check_byte({6'h00, power_down_select, counts_per_inch_select}, 8'(k), "pins");
		end
		run_frame(1);
		rd(ADDR_BRIGHTEST, 8'(r_max), "powered down");
		u_mcu.write_reg(ADDR_CONFIG, 8'h00);
		r_sleep = 0;
		$display("test config done");
		for (int m = 0; m < 3; m++) begin
			run_frame(m);
			rd(ADDR_BRIGHTEST, 8'(r_max), "brightest");
			rd(ADDR_TOTAL, 8'(r_tot), "total");
			rd(ADDR_DARKEST, 8'(r_min), "darkest");
			rd(ADDR_EXPO_HIGH, 8'(r_expo >> 8), "expo high");
			rd(ADDR_EXPO_LOW, 8'(r_expo), "expo low");
			check_word(exposure, 16'(r_expo), "exposure");
		end
		$display("test stats done");
		u_mcu.write_reg(ADDR_SAMPLE, 8'($urandom));
		s_idx = 0;
		s_arm = 1;
		s_val = 0;
		run_frame(0);
		run_frame(0);
		grab("first grab");
		grab("stale grab");
		run_frame(2);
		grab("next grab");
		$display("test sampler done");
		move(100, -100, 8'h33);
		move(100, -100, 8'h44);
		rd(ADDR_DELTA_X, 8'(r_dx), "dx");
		rd(ADDR_DELTA_Y, 8'(r_dy), "dy");
		rd(ADDR_DELTA_X, 8'h00, "dx cleared");
		rd(ADDR_DELTA_Y, 8'h00, "dy cleared");
		r_dx = 0;
		r_dy = 0;
		move(int'($urandom_range(60)) - 30, int'($urandom_range(60)) - 30, $urandom_range(144));
		want = '{r_dx, r_dy, r_sq, r_expo >> 8, r_expo, r_max, r_tot, r_tot, r_tot};
		u_mcu.bulk_read(9);
		for (int k = 0; k < 9; k++) begin
			check_byte(u_mcu.bulk[k], 8'(want[k]), "burst");
		end
		check_byte({7'h00, sdio_oe}, 8'h00, "released");
		rd(ADDR_DARKEST, 8'(r_min), "after burst");
		$display("test burst done");
		u_mcu.write_reg(ADDR_CONFIG, 8'h03);
		u_mcu.write_reg(ADDR_SOFT_RESET, 8'h11);
		rd(ADDR_CONFIG, 8'h03, "wrong key");
		u_mcu.write_reg(ADDR_SOFT_RESET, RESET_KEY);
		repeat (8) @(negedge clock);
		ref_reset();
		rd(ADDR_CONFIG, 8'h00, "soft reset config");
		rd(ADDR_BRIGHTEST, 8'h00, "soft reset stats");
		check_word(exposure, EXPO_RESET, "soft reset exposure");
		$display("test soft reset done");
		close_out();
	end
endmodule // tb_top
